// ===== core/bef_defines.vh
// Constants for the bridge excitation, filter pacing and output word block.
// Assumes one master clock at 100 MHz and an APB slave with 32-bit data.
// Behaviour
// RULE_01: Source bit zero selects internal excitation, divided from master clock by frequency select.
// RULE_02: Internal mode, nonzero select: both excite pins form two-phase non-overlapping clock.
// RULE_03: Both excite outputs stay low exactly one master cycle between phases.
// RULE_04: Source bit one makes excite pin A an input setting frequency and phase.
// RULE_05: External clock near 50% duty, synchronous, N times master over 81920, N 1..160.
// RULE_06: External mode regenerates excite pin B from pin A for the bridge amplifier.
// RULE_07: After every excite output change, wait 64 master cycles before sampling inputs.
// RULE_08: Filter delivers one output word every 81920 master cycles.
// RULE_09: After step, gain or offset change, up to 6 words until settled.
// RULE_10: Unipolar results are straight binary, bipolar results are two's complement.
// RULE_11: Word shifts out MSB or sign first, next bit on each falling serial clock.
// RULE_12: Word is 24 bits: 16 or 20 data bits, rest copies of flag.
// RULE_13: Host must give 17 or 21 serial clocks to get data plus a flag.
// RULE_14: Flag bits are zero normally and all one when input is over range.
// RULE_15: Beyond twice full scale flags set, data need not be a full-scale code.
// RULE_16: First word after reset or restart may show false flags; host ignores it.
// RULE_17: Source and select all zero: pin A driven low, pin B high.
// RULE_18: After filter reset one then zero, filter starts after 24th serial clock falls.
// RULE_19: Hold-off counter restarts on every excite edge; no sample until it expires.
`ifndef BEF_DEFINES_VH
`define BEF_DEFINES_VH

// Register byte offsets
`define BEF_ADDR_CTRL     12'h000
`define BEF_ADDR_STATUS   12'h004
`define BEF_ADDR_INT_STAT 12'h008
`define BEF_ADDR_INT_CLR  12'h00C
`define BEF_ADDR_INT_EN   12'h010
`define BEF_ADDR_DATA     12'h014

// Control register fields
`define BEF_CTRL_EXC_SRC  0
`define BEF_CTRL_FSEL_LO  1
`define BEF_CTRL_FSEL_HI  2
`define BEF_CTRL_FRST     3
`define BEF_CTRL_BIPOLAR  4
`define BEF_CTRL_RES20    5
`define BEF_CTRL_W        6
`define BEF_CTRL_RESET    6'h00

// Interrupt bits: word ready, over range, settled
`define BEF_INT_WORD      0
`define BEF_INT_OVR       1
`define BEF_INT_SETTLED   2
`define BEF_INT_W         3

// Timing counts in master cycles; settling in words, filter restart in serial clocks
`define BEF_WORD_CYCLES   81920
`define BEF_HOLDOFF       64
`define BEF_SETTLE_WORDS  6
`define BEF_FRST_SCLKS    24
`define BEF_EXC_HALF_1    4096
`define BEF_EXC_HALF_2    2048
`define BEF_EXC_HALF_3    1024

// Word layout
`define BEF_WORD_W        24
`define BEF_ACC_W         21

`endif

// ===== core/bef_sync2.v
// Two-flop synchroniser for pins entering the master clock domain.
// Assumes inputs are asynchronous levels; first stage feeds second only.
`timescale 1ns/1ps
`default_nettype none
module bef_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_r;

  // Two stages, reset to zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== core/bef_dcnt.v
// Loadable down counter with a zero flag, used for hold-off and settling.
// Assumes load and dec come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bef_dcnt #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         load,
  input  wire [W-1:0] load_val,
  input  wire         dec,
  output wire         zero
);
  reg [W-1:0] cnt_r;

  // Load wins over decrement so a new event always restarts the wait
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {W{1'b0}};
    end else if (load) begin
      cnt_r <= load_val;
    end else if (dec && (cnt_r != {W{1'b0}})) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign zero = (cnt_r == {W{1'b0}});
endmodule
`default_nettype wire

// ===== core/bef_top.v
// Bridge excitation, sampling hold-off, filter pacing and output word block.
// Assumes pclk is the master clock; serial clock and excite pin A are async pins;
// filter accumulator and over-range hints come from logic on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "bef_defines.vh"
module bef_top #(
  parameter WORD_CYCLES = `BEF_WORD_CYCLES
) (
  input  wire                  pclk,
  input  wire                  presetn,
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [11:0]           paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  output reg                   irq,
  input  wire                  bridge_excite_a_i,
  output reg                   bridge_excite_a_o,
  output reg                   bridge_excite_a_oe,
  output reg                   bridge_excite_b,
  output reg                   sample_enable,
  output reg                   filter_tick,
  input  wire [`BEF_ACC_W-1:0] filter_acc,
  input  wire                  filter_acc_wild,
  input  wire                  settle_restart,
  input  wire                  serial_clk,
  output reg                   serial_data,
  output reg                   serial_data_oe
);
  // One-hot excitation phases
  localparam [3:0] EX_A  = 4'b0001;
  localparam [3:0] EX_DA = 4'b0010;
  localparam [3:0] EX_B  = 4'b0100;
  localparam [3:0] EX_DB = 4'b1000;
  localparam [16:0] WORD_LAST = WORD_CYCLES[16:0] - 17'd1;

  reg  [`BEF_CTRL_W-1:0]  ctrl_r;
  reg  [`BEF_INT_W-1:0]   int_stat_r;
  reg  [`BEF_INT_W-1:0]   int_en_r;
  reg  [`BEF_WORD_W-1:0]  data_r;
  reg  [3:0]              ex_state_r;
  reg  [12:0]             ex_cnt_r;
  reg  [12:0]             ex_half;
  reg                     nxt_a;
  reg                     nxt_b;
  reg  [16:0]             word_cnt_r;
  reg                     fr_wait_r;
  reg  [4:0]              fr_cnt_r;
  reg                     first_word_r;
  reg                     settled_r;
  reg  [`BEF_WORD_W-1:0]  shreg_r;
  reg  [4:0]              sh_cnt_r;
  reg                     sclk_d_r;
  reg  signed [21:0]      v;
  reg  signed [21:0]      hi;
  reg  signed [21:0]      lo;
  reg  signed [21:0]      clamp;
  reg                     ovr;
  reg  [`BEF_WORD_W-1:0]  word_nxt;
  reg  [31:0]             rd_nxt;
  reg                     map_ok;
  wire                    bxa_s;
  wire                    sclk_s;
  wire                    holdoff_zero;
  wire                    settle_zero;

  wire       exc_src   = ctrl_r[`BEF_CTRL_EXC_SRC];
  wire [1:0] fsel      = {ctrl_r[`BEF_CTRL_FSEL_HI], ctrl_r[`BEF_CTRL_FSEL_LO]};
  wire       int_run   = !exc_src && (fsel != 2'b00);
  wire       apb_acc   = psel && penable && pready;
  wire       apb_wr    = apb_acc && pwrite;
  wire       wr_ctrl   = apb_wr && (paddr == `BEF_ADDR_CTRL);
  wire       sclk_fall = sclk_d_r && !sclk_s;
  wire       filt_run  = !ctrl_r[`BEF_CTRL_FRST] && !fr_wait_r;
  wire       word_tick = filt_run && (word_cnt_r == WORD_LAST);
  wire       exc_edge  = (nxt_a != bridge_excite_a_o) || (nxt_b != bridge_excite_b);
  wire       fr_release = wr_ctrl && ctrl_r[`BEF_CTRL_FRST] && !pwdata[`BEF_CTRL_FRST];

  // Pins from outside the clock domain
  bef_sync2 #(
    .W (2)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   ({bridge_excite_a_i, serial_clk}),
    .dout  ({bxa_s, sclk_s})
  );

  // Sampling hold-off restarted by each excite edge
  bef_dcnt #(
    .W (7)
  ) u_holdoff (
    .clk      (pclk),
    .rst_n    (presetn),
    .load     (exc_edge),                        // RULE_19
    .load_val (7'd`BEF_HOLDOFF),                 // RULE_07
    .dec      (1'b1),
    .zero     (holdoff_zero)
  );

  // Words still needed before output is settled
  bef_dcnt #(
    .W (3)
  ) u_settle (
    .clk      (pclk),
    .rst_n    (presetn),
    .load     (settle_restart || fr_release),
    .load_val (3'd`BEF_SETTLE_WORDS),            // RULE_09
    .dec      (word_tick),
    .zero     (settle_zero)
  );

  // Half period of the internal excitation, one dead cycle included
  always @* begin
    case (fsel)
      2'b01:   ex_half = 13'd`BEF_EXC_HALF_1;    // RULE_01
      2'b10:   ex_half = 13'd`BEF_EXC_HALF_2;
      2'b11:   ex_half = 13'd`BEF_EXC_HALF_3;
      default: ex_half = 13'd`BEF_EXC_HALF_1;
    endcase
  end

  // Internal two-phase sequencer; idles in phase A when not running
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ex_state_r <= EX_A;
      ex_cnt_r   <= 13'h0000;
    end else if (!int_run) begin
      ex_state_r <= EX_A;
      ex_cnt_r   <= 13'h0000;
    end else begin
      case (ex_state_r)
        EX_A: begin
          if (ex_cnt_r >= ex_half - 13'd2) begin
            ex_cnt_r   <= 13'h0000;
            ex_state_r <= EX_DA;
          end else begin
            ex_cnt_r <= ex_cnt_r + 13'd1;
          end
        end
        EX_DA: ex_state_r <= EX_B;                // RULE_03
        EX_B: begin
          if (ex_cnt_r >= ex_half - 13'd2) begin
            ex_cnt_r   <= 13'h0000;
            ex_state_r <= EX_DB;
          end else begin
            ex_cnt_r <= ex_cnt_r + 13'd1;
          end
        end
        EX_DB: ex_state_r <= EX_A;                // RULE_03
        default: ex_state_r <= EX_A;
      endcase
    end
  end

  // Next pin levels for each excitation mode
  always @* begin
    if (exc_src) begin
      nxt_a = 1'b0;
      nxt_b = bxa_s;                              // RULE_06
    end else if (fsel == 2'b00) begin
      nxt_a = 1'b0;                               // RULE_17
      nxt_b = 1'b1;
    end else begin
      nxt_a = (ex_state_r == EX_A);               // RULE_02
      nxt_b = (ex_state_r == EX_B);
    end
  end

  // Excite pins registered; pin A released as input in external mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_excite_a_o  <= 1'b0;
      bridge_excite_a_oe <= 1'b1;
      bridge_excite_b    <= 1'b1;
      sample_enable      <= 1'b0;
    end else begin
      bridge_excite_a_o  <= nxt_a;
      bridge_excite_a_oe <= !exc_src;             // RULE_04
      bridge_excite_b    <= nxt_b;
      sample_enable      <= holdoff_zero && !exc_edge; // RULE_19
    end
  end

  // Output word formatting with clamp and flag copies
  always @* begin
    if (ctrl_r[`BEF_CTRL_RES20]) begin
      v = {filter_acc[20], filter_acc};
    end else begin
      v = {{5{filter_acc[20]}}, filter_acc[20:4]};
    end
    case ({ctrl_r[`BEF_CTRL_BIPOLAR], ctrl_r[`BEF_CTRL_RES20]})
      2'b00: begin hi = 22'sh00FFFF; lo = 22'sh000000; end  // RULE_10
      2'b01: begin hi = 22'sh0FFFFF; lo = 22'sh000000; end
      2'b10: begin hi = 22'sh007FFF; lo = 22'sh3F8000; end
      default: begin hi = 22'sh07FFFF; lo = 22'sh380000; end
    endcase
    ovr = filter_acc_wild || (v > hi) || (v < lo);          // RULE_14
    if (filter_acc_wild) begin
      clamp = v;                                  // RULE_15
    end else if (v > hi) begin
      clamp = hi;
    end else if (v < lo) begin
      clamp = lo;
    end else begin
      clamp = v;
    end
    if (ctrl_r[`BEF_CTRL_RES20]) begin
      word_nxt = {clamp[19:0], {4{ovr}}};         // RULE_12
    end else begin
      word_nxt = {clamp[15:0], {8{ovr}}};
    end
  end

  // Word pacing; held at zero during filter reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_cnt_r  <= 17'h00000;
      filter_tick <= 1'b0;
    end else begin
      filter_tick <= word_tick;
      if (!filt_run || word_tick) begin
        word_cnt_r <= 17'h00000;                  // RULE_08
      end else begin
        word_cnt_r <= word_cnt_r + 17'd1;
      end
    end
  end

  // Filter restart waits for 24 serial clock falls after reset release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_wait_r <= 1'b0;
      fr_cnt_r  <= 5'h00;
    end else if (fr_release) begin
      fr_wait_r <= 1'b1;
      fr_cnt_r  <= 5'h00;
    end else if (fr_wait_r && sclk_fall) begin
      if (fr_cnt_r == 5'd`BEF_FRST_SCLKS - 5'd1) begin
        fr_wait_r <= 1'b0;                        // RULE_18
      end
      fr_cnt_r <= fr_cnt_r + 5'd1;
    end
  end

  // Serial shifter, loaded with each new word; host gives the clocks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r       <= 1'b0;
      shreg_r        <= 24'h000000;
      sh_cnt_r       <= 5'h00;
      serial_data    <= 1'b0;
      serial_data_oe <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      if (word_tick) begin
        shreg_r        <= word_nxt;
        sh_cnt_r       <= 5'd`BEF_WORD_W;
        serial_data    <= word_nxt[`BEF_WORD_W-1];  // RULE_11
        serial_data_oe <= 1'b1;
      end else if (sclk_fall && (sh_cnt_r != 5'h00)) begin
        shreg_r        <= {shreg_r[`BEF_WORD_W-2:0], 1'b0};
        serial_data    <= shreg_r[`BEF_WORD_W-2];   // RULE_11
        sh_cnt_r       <= sh_cnt_r - 5'd1;
        serial_data_oe <= (sh_cnt_r != 5'd1);     // RULE_13
      end
    end
  end

  // Captured word, first-word marker and settled level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r       <= 24'h000000;
      first_word_r <= 1'b1;
      settled_r    <= 1'b0;
    end else begin
      if (word_tick) begin
        data_r <= word_nxt;
      end
      // Flags of the first word after reset or restart are not trusted
      if (fr_release) begin
        first_word_r <= 1'b1;                     // RULE_16
      end else if (word_tick) begin
        first_word_r <= 1'b0;
      end
      settled_r <= settle_zero;
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= 3'h0;
      irq        <= 1'b0;
    end else begin
      if (apb_wr && (paddr == `BEF_ADDR_INT_CLR)) begin
        int_stat_r <= (int_stat_r & ~pwdata[2:0]) |
                      {settle_zero && !settled_r, word_tick && ovr, word_tick};
      end else begin
        int_stat_r <= int_stat_r |
                      {settle_zero && !settled_r, word_tick && ovr, word_tick};
      end
      irq <= |(int_stat_r & int_en_r);
    end
  end

  // Register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= `BEF_CTRL_RESET;
      int_en_r <= 3'h0;
    end else if (apb_wr) begin
      if (paddr == `BEF_ADDR_CTRL) begin
        ctrl_r <= pwdata[`BEF_CTRL_W-1:0];
      end
      if (paddr == `BEF_ADDR_INT_EN) begin
        int_en_r <= pwdata[2:0];
      end
    end
  end

  // Read mux and address map check
  always @* begin
    map_ok = 1'b1;
    rd_nxt = 32'h00000000;
    case (paddr)
      `BEF_ADDR_CTRL:     rd_nxt = {26'h0, ctrl_r};
      `BEF_ADDR_STATUS:   rd_nxt = {24'h0, ex_state_r, first_word_r,
                                    settled_r, filt_run, holdoff_zero};
      `BEF_ADDR_INT_STAT: rd_nxt = {29'h0, int_stat_r};
      `BEF_ADDR_INT_CLR:  rd_nxt = 32'h00000000;
      `BEF_ADDR_INT_EN:   rd_nxt = {29'h0, int_en_r};
      `BEF_ADDR_DATA:     rd_nxt = {8'h00, data_r};
      default:            map_ok = 1'b0;
    endcase
  end

  // APB answer: one wait state, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !map_ok;
      prdata  <= pwrite ? 32'h00000000 : rd_nxt;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== verification/bef_chk_sva.sv
// Port checker for the excitation, hold-off, pacing and word blocks.
// Assumes it is bound to bef_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module bef_chk #(
  parameter int WORD_CYCLES = 81920
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bridge_excite_a_i,
  input wire logic bridge_excite_a_o,
  input wire logic bridge_excite_a_oe,
  input wire logic bridge_excite_b,
  input wire logic sample_enable,
  input wire logic filter_tick,
  input wire logic serial_clk,
  input wire logic serial_data
);
  logic        a_q_r;
  logic        b_q_r;
  logic        seen_r;
  logic [7:0]  hold_r;
  logic [31:0] gap_r;
  logic        exc_chg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Any change on a driven excite pin restarts the watch
  assign exc_chg = (bridge_excite_a_oe && bridge_excite_a_o != a_q_r)
                 || bridge_excite_b != b_q_r;

  // Saturating at 255 so a fresh reset never looks like a change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q_r  <= 1'b0;
      b_q_r  <= 1'b1;
      hold_r <= 8'hFF;
      gap_r  <= 32'h0;
      seen_r <= 1'b0;
    end else begin
      a_q_r  <= bridge_excite_a_o;
      b_q_r  <= bridge_excite_b;
      hold_r <= exc_chg ? 8'h00 : (hold_r == 8'hFF ? hold_r : hold_r + 8'h01);
      gap_r  <= filter_tick ? 32'h1 : gap_r + 32'h1;
      seen_r <= seen_r | filter_tick;
    end
  end

  sequence s_ext_rise;
    (!bridge_excite_a_oe && $rose(bridge_excite_a_i))
      ##1 (!bridge_excite_a_oe && bridge_excite_a_i) [*5];
  endsequence

  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  property p_one_wait;
    psel && $rose(penable) |=> pready;
  endproperty
  property p_err_with_rdy;
    pslverr |-> pready;
  endproperty
  property p_no_overlap;
    !(bridge_excite_a_oe && bridge_excite_a_o && bridge_excite_b);
  endproperty
  property p_dead_cycle;
    $fell(bridge_excite_a_o) && bridge_excite_a_oe && !bridge_excite_b |=> bridge_excite_b;
  endproperty
  property p_hold_low;
    sample_enable |-> hold_r >= 8'd62;
  endproperty
  property p_hold_end;
    hold_r == 8'd70 |-> sample_enable;
  endproperty
  property p_word_gap;
    filter_tick && seen_r |-> gap_r >= WORD_CYCLES;
  endproperty
  property p_ext_follow;
    s_ext_rise |-> bridge_excite_b;
  endproperty
  property p_shift_on_fall;
    !serial_clk [*8] |=> $stable(serial_data) || filter_tick;
  endproperty

  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  a_one_wait: assert property (p_one_wait) else $error("pready not after one wait");
  a_err_with_rdy: assert property (p_err_with_rdy) else $error("pslverr without pready");
  a_no_overlap: assert property (p_no_overlap)
    else $error("excite phases overlap");
  a_dead_cycle: assert property (p_dead_cycle)
    else $error("dead time between phases not one cycle");
  a_hold_low: assert property (p_hold_low)
    else $error("sampling inside hold-off");
  a_hold_end: assert property (p_hold_end)
    else $error("hold-off never expired");
  a_word_gap: assert property (p_word_gap)
    else $error("words closer than the word period");
  a_ext_follow: assert property (p_ext_follow)
    else $error("pin B not following external clock");
  a_shift_on_fall: assert property (p_shift_on_fall)
    else $error("serial data moved without a falling clock");
endmodule

bind bef_top bef_chk #(.WORD_CYCLES(WORD_CYCLES)) chk_u (.*);
`default_nettype wire

// ===== verification/bef_far_model.sv
// Far side: external excitation source and host serial reader.
// Assumes the same master clock as the block; serial clock idles low.
`timescale 1ns/1ps
`default_nettype none
module bef_far_model #(
  parameter int EXC_HALF = 256
) (
  input  wire logic pclk,
  input  wire logic ext_on,
  input  wire logic serial_data,
  output var  logic serial_clk,
  output var  logic exc_a
);
  int cnt_r = 0;

  initial serial_clk = 1'b0;
  initial exc_a = 1'b1;

  // Synchronous square wave, N of 160; pulled up (dc) while off
  always @(posedge pclk) begin
    cnt_r <= (cnt_r == EXC_HALF - 1) ? 0 : cnt_r + 1;
    if (!ext_on)
      exc_a <= 1'b1;
    else if (cnt_r == EXC_HALF - 1)
      exc_a <= ~exc_a;
  end

  // Sample each bit before its falling edge; slow bursts, one per bit
  task automatic read_word(output logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      w[i] = serial_data;
      @(posedge pclk);
      serial_clk <= 1'b1;
      repeat (8) @(posedge pclk);
      serial_clk <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ===== verification/bridge_excitation_filter_output_tb.sv
// Self-checking bench for bef_top with APB register access.
// Assumes bef_far_model as host and excitation source; short word period.
`timescale 1ns/1ps
`default_nettype none
`include "bef_defines.vh"
module bridge_excitation_filter_output_tb;
  localparam int WC = 1000;
  logic        pclk;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [20:0] acc = 21'h0;
  logic        wild = 1'b0;
  logic        settle = 1'b0;
  logic        ext_on = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, a_i, a_o, a_oe, exc_b, smp_en, tick;
  logic        sclk, sdat, sdat_oe;
  int          n_errors = 0;
  int          total_checks = 0;

  bef_top #(.WORD_CYCLES(WC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .bridge_excite_a_i(a_i),
    .bridge_excite_a_o(a_o), .bridge_excite_a_oe(a_oe), .bridge_excite_b(exc_b),
    .sample_enable(smp_en), .filter_tick(tick), .filter_acc(acc),
    .filter_acc_wild(wild), .settle_restart(settle), .serial_clk(sclk),
    .serial_data(sdat), .serial_data_oe(sdat_oe));
  bef_far_model far_u (.pclk(pclk), .ext_on(ext_on), .serial_data(sdat),
    .serial_clk(sclk), .exc_a(a_i));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s exp %0h got %0h", nm, e, g);
      n_errors++;
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic tick_wait(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tick !== 1'b1);
  endtask

  task automatic t_reset;
    logic [31:0] q;
    logic e;
    chk("dc pin a", 32'h0, a_o);
    chk("dc pin b", 32'h1, exc_b);
    rd(`BEF_ADDR_CTRL, q);
    chk("ctrl reset", 32'h0, q);
    apb(1'b0, 12'h0FC, 32'h0, q, e);
    chk("unmapped err", 32'h1, e);
  endtask

  // Phase length, dead time and hold-off for each internal divider
  task automatic t_exc;
    int h, d, se;
    for (int f = 1; f < 4; f++) begin
      wr(`BEF_ADDR_CTRL, f << 1);
      repeat (2) @(posedge a_o);
      h = 0;
      se = 0;
      @(posedge pclk);
      while (a_o === 1'b1) begin
        h++;
        if (se == 0 && smp_en === 1'b1) se = h;
        @(posedge pclk);
      end
      d = 0;
      while (a_o !== 1'b1 && exc_b !== 1'b1) begin
        d++;
        @(posedge pclk);
      end
      chk("a high", (4096 >> (f - 1)) - 1, h);
      chk("dead", 32'h1, d);
      chk("holdoff", 32'h1, se >= 64 && se <= 66);
    end
    wr(`BEF_ADDR_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    chk("dc again", 32'h1, {a_o, exc_b} === 2'b01);
  endtask

  // Coding, flags and serial order over a table of settings
  task automatic t_words;
    logic [5:0]  cf [7] = '{6'h20, 6'h20, 6'h30, 6'h30, 6'h00, 6'h00, 6'h00};
    logic [20:0] ac [7] = '{21'h0ABCDE, 21'h100000, 21'h1FFFFF, 21'h080000,
                            21'h0ABCDE, 21'h0FFFFF, 21'h000010};
    logic [23:0] ex [7] = '{24'hABCDE0, 24'h00000F, 24'hFFFFF0, 24'h7FFFFF,
                            24'hABCD00, 24'hFFFF00, 24'h0000FF};
    logic [23:0] w, m;
    logic [31:0] q;
    int n;
    for (int i = 0; i < 7; i++) begin
      wr(`BEF_ADDR_CTRL, cf[i]);
      acc <= ac[i];
      wild <= (i == 6);
      m = (i == 6) ? 24'h0000FF : 24'hFFFFFF;
      tick_wait(n);
      tick_wait(n);
      chk("word gap", WC, n);
      far_u.read_word(w);
      chk("serial word", ex[i], w & m);
      chk("oe after 24", 32'h0, sdat_oe);
      rd(`BEF_ADDR_DATA, q);
      chk("data reg", ex[i], q[23:0] & m);
    end
    wild <= 1'b0;
  endtask

  // Filter held after reset bit until 24 serial clocks fall
  task automatic t_frst;
    logic [23:0] w;
    logic [31:0] q;
    int k, n;
    wr(`BEF_ADDR_CTRL, 32'h8);
    wr(`BEF_ADDR_CTRL, 32'h0);
    rd(`BEF_ADDR_STATUS, q);
    chk("first word mark", 32'h1, q[3]);
    k = 0;
    repeat (2500) begin
      @(posedge pclk);
      if (tick === 1'b1) k++;
    end
    chk("held ticks", 32'h0, k);
    far_u.read_word(w);
    tick_wait(n);
    chk("restart", 32'h1, n >= 980 && n <= WC);
    rd(`BEF_ADDR_STATUS, q);
    chk("first word gone", 32'h0, q[3]);
  endtask

  task automatic t_irq;
    logic [31:0] q;
    int n;
    wr(`BEF_ADDR_INT_EN, 32'h1);
    tick_wait(n);
    repeat (2) @(posedge pclk);
    chk("irq set", 32'h1, irq);
    wr(`BEF_ADDR_INT_CLR, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq clr", 32'h0, irq);
    rd(`BEF_ADDR_INT_CLR, q);
    chk("clr reads 0", 32'h0, q);
    wr(`BEF_ADDR_INT_EN, 32'h0);
    tick_wait(n);
    repeat (3) @(posedge pclk);
    chk("irq masked", 32'h0, irq);
    rd(`BEF_ADDR_INT_STAT, q);
    chk("stat word", 32'h1, q[0]);
  endtask

  task automatic t_ext;
    ext_on <= 1'b1;
    wr(`BEF_ADDR_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    chk("a input", 32'h0, a_oe);
    repeat (4) begin
      @(a_i);
      repeat (8) @(posedge pclk);
      chk("b follows", a_i, exc_b);
    end
    ext_on <= 1'b0;
    wr(`BEF_ADDR_CTRL, 32'h0);
  endtask

  task automatic t_settle;
    logic [31:0] q;
    int n;
    // Start just after a word so no tick slips past uncounted
    tick_wait(n);
    settle <= 1'b1;
    @(posedge pclk);
    settle <= 1'b0;
    rd(`BEF_ADDR_STATUS, q);
    chk("unsettled", 32'h0, q[2]);
    repeat (5) tick_wait(n);
    rd(`BEF_ADDR_STATUS, q);
    chk("still settling", 32'h0, q[2]);
    repeat (2) tick_wait(n);
    rd(`BEF_ADDR_STATUS, q);
    chk("settled", 32'h1, q[2]);
  endtask

  task wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Whole run is near 53k cycles; cut off at 90k
  initial begin
    #900000;
    n_errors++;
    $display("[FAIL] watchdog exp done got hang");
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_exc();
    t_words();
    t_frst();
    t_irq();
    t_ext();
    t_settle();
    wrap_up();
  end
endmodule
`default_nettype wire
